/* logic/wdg_top.v */
// Summary of operation
// (R1) counter advances on the separate 1 MHz oscillator, not system clock
// (R2) watchdog-clear strobe zeroes the counter and restarts the period
// (R3) counter also cleared when disabled and on any chip reset
// (R4) selected period elapsing without clear raises a chip reset
// (R5) two fuses pick level 0, 1 or 2; level 2 starts enabled
// (R6) writing enable as one enables at once at every level
// (R7) level 0 takes new period bits on any write
// (R8) software opens the window writing change-enable and enable together
// (R9) level 1 accepts disable or period change only inside the window
// (R10) level 2 keeps the watchdog on and enable reads one
// (R11) level 2 period change needs the window; enable value ignored
// (R12) level 2 never disables, even after a full sequence
// (R13) change-enable clears itself four clocks after being written one
// (R14) enable clears only while change-enable is one
// (R15) control register at 0x21, reset 0x00, bits 4, 3, 2..0
// (R16) scan flag set by scan reset, cleared by power-on or software
// (R17) timeout flag set by watchdog reset, cleared likewise
// (R18) low supply flag set by brown-out, cleared likewise
// (R19) pin flag set by external reset, cleared likewise
// (R20) power-up flag set on power-on, cleared only by software
// (R21) in compat mode only pin and power-up flags exist
// (R22) registers reached at I/O offset or data offset plus 0x20
// (R23) expiry gives a one-clock internal reset pulse
// (R24) select 0..7 gives 16384 doubling to 2097152 oscillator cycles
// (R25) fuses are sampled once after reset and held
`timescale 1ns/1ns
`default_nettype none
`include "wdg_defines.vh"

module wdg_top #(
  parameter BASE_PERIOD = `WDG_BASE_PERIOD,
  parameter CNT_WIDTH   = `WDG_CNT_WIDTH
) (
  input  wire       clock,
  input  wire       nrst,
  input  wire       osc_clock,
  input  wire       legacy_compat_fuse,
  input  wire       watchdog_always_on_fuse,
  input  wire       power_up_src,
  input  wire       pin_reset_src,
  input  wire       low_supply_src,
  input  wire       scan_reset_src,
  input  wire       wdg_clear,
  input  wire [7:0] bus_addr,
  input  wire       bus_io,
  input  wire       bus_wr,
  input  wire       bus_rd,
  input  wire [7:0] bus_wdata,
  output reg  [7:0] bus_rdata,
  output reg        wdg_reset,
  output reg        wdg_active,
  output reg  [1:0] safety_level
);

  // ****************************************
  // address decode
  // ****************************************
  // port access uses the I/O offset, load/store adds the data offset
  function hit;
    input [7:0] addr;
    input       io;
    input [7:0] offset;
    begin
      if (io)
        hit = (addr == offset); // R22
      else
        hit = (addr == offset + `WDG_DATA_OFFSET); // R22
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  // synchronised pins, decodes and write fields
  wire [6:0] pins_sync;
  wire       osc_sync;
  wire       compat_sync;
  wire       on_sync;
  wire       por_s;
  wire       pin_s;
  wire       low_s;
  wire       scan_s;
  wire       ctrl_hit;
  wire       flag_hit;
  wire       ctrl_wr;
  wire       flag_wr;
  wire       osc_tick;
  wire       expire;
  wire       chip_reset;
  wire       counter_clear;
  wire       wr_ce;
  wire       wr_en;
  wire [2:0] wr_ps;
  wire [7:0] ctrl_view;

  // state registers
  reg        osc_prev;
  reg        fuse_taken;
  reg        compat_mode;
  reg        ce_bit;
  reg [2:0]  ce_count;
  reg        en_bit;
  reg [2:0]  period_select_field;
  reg [7:0]  flags;

  // next values and flag terms
  reg        next_ce_bit;
  reg [2:0]  next_ce_count;
  reg        next_en_bit;
  reg [2:0]  next_period;
  reg [7:0]  next_flags;
  reg [7:0]  flag_set;
  reg [7:0]  flag_keep;

  // ****************************************
  // input synchronisers
  // ****************************************
  // every pin level passes two flops before use
  wdg_sync #(
    .WIDTH (7)
  ) u_sync (
    .clock (clock),
    .d     ({osc_clock, legacy_compat_fuse,
             watchdog_always_on_fuse, power_up_src,
             pin_reset_src, low_supply_src,
             scan_reset_src}),
    .q     (pins_sync)
  );

  // split the synchronised bus back into pins
  assign osc_sync    = pins_sync[6];
  assign compat_sync = pins_sync[5];
  assign on_sync     = pins_sync[4];
  assign por_s       = pins_sync[3];
  assign pin_s       = pins_sync[2];
  assign low_s       = pins_sync[1];
  assign scan_s      = pins_sync[0];

  // ****************************************
  // oscillator edge detect
  // ****************************************
  // one tick per rising oscillator edge
  always @(posedge clock) begin
    if (!nrst)
      osc_prev <= 1'b0;
    else
      osc_prev <= osc_sync;
  end

  assign osc_tick = osc_sync & ~osc_prev; // R1

  // ****************************************
  // fuse capture and safety level
  // ****************************************
  // fuses latched once, first cycles after release
  always @(posedge clock) begin
    if (!nrst) begin
      fuse_taken   <= 1'b0;
      compat_mode  <= 1'b0;
      safety_level <= `WDG_LEVEL1;
    end else if (!fuse_taken) begin
      fuse_taken  <= 1'b1; // R25
      compat_mode <= compat_sync;
      if (on_sync)
        safety_level <= `WDG_LEVEL2; // R5
      else if (compat_sync)
        safety_level <= `WDG_LEVEL0; // R5
      else
        safety_level <= `WDG_LEVEL1; // R5
    end
  end

  // ****************************************
  // bus strobes and write fields
  // ****************************************
  // register select, write strobes and written fields
  assign ctrl_hit = hit(bus_addr, bus_io, `WDG_CTRL_IO);
  assign flag_hit = hit(bus_addr, bus_io, `WDG_FLAGS_IO);
  assign ctrl_wr  = bus_wr & ctrl_hit;
  assign flag_wr  = bus_wr & flag_hit;
  assign wr_ce    = bus_wdata[`WDG_CE_BIT];
  assign wr_en    = bus_wdata[`WDG_EN_BIT];
  assign wr_ps    = bus_wdata[`WDG_PS_HI:`WDG_PS_LO];

  // any active source resets the chip, as does expiry
  assign chip_reset = por_s | pin_s | low_s | scan_s | wdg_reset;

  // ****************************************
  // control register next state
  // ****************************************
  // window, enable and period update rules per level
  always @* begin
    next_ce_bit   = ce_bit;
    next_ce_count = ce_count;
    next_en_bit   = en_bit;
    next_period   = period_select_field;
    // window closes itself after four clocks
    if (ce_bit) begin
      if (ce_count <= 3'h1) begin
        next_ce_bit   = 1'b0; // R13
        next_ce_count = 3'h0;
      end else begin
        next_ce_count = ce_count - 3'h1; // R13
      end
    end
    if (ctrl_wr) begin
      // period bits
      if (safety_level == `WDG_LEVEL0)
        next_period = wr_ps; // R7
      else if (ce_bit)
        next_period = wr_ps; // R9 R11
      // enable bit
      if (wr_en)
        next_en_bit = 1'b1; // R6
      else if (ce_bit && safety_level != `WDG_LEVEL2)
        next_en_bit = 1'b0; // R9 R14
      // opening write needs enable written one too
      if (wr_ce && wr_en) begin
        next_ce_bit   = 1'b1; // R8 R13
        next_ce_count = `WDG_CE_CYCLES;
      end else if (!wr_ce) begin
        next_ce_bit   = 1'b0;
        next_ce_count = 3'h0;
      end
    end
    // level 2 can never be off
    if (safety_level == `WDG_LEVEL2)
      next_en_bit = 1'b1; // R10 R12
  end

  // ****************************************
  // control register
  // ****************************************
  // chip reset restores the reset value
  always @(posedge clock) begin
    if (!nrst || chip_reset) begin
      ce_bit              <= 1'b0; // R15
      ce_count            <= 3'h0;
      en_bit              <= 1'b0;
      period_select_field <= 3'h0;
    end else begin
      ce_bit              <= next_ce_bit;
      ce_count            <= next_ce_count;
      en_bit              <= next_en_bit;
      period_select_field <= next_period;
    end
  end

  // level 2 reads enable as one
  assign ctrl_view = {3'h0, ce_bit,
                      en_bit | (safety_level == `WDG_LEVEL2),
                      period_select_field}; // R10 R15

  // ****************************************
  // watchdog counter
  // ****************************************
  // clear on instruction, on disable, on chip reset
  assign counter_clear = wdg_clear | chip_reset; // R2 R3

  wdg_counter #(
    .WIDTH (CNT_WIDTH),
    .BASE  (BASE_PERIOD)
  ) u_counter (
    .clock  (clock),
    .nrst   (nrst),
    .tick   (osc_tick),
    .clear  (counter_clear),
    .run    (ctrl_view[`WDG_EN_BIT]), // R3
    .sel    (period_select_field), // R24
    .expire (expire)
  );

  // ****************************************
  // reset pulse
  // ****************************************
  // exactly one clock per expiry
  always @(posedge clock) begin
    if (!nrst) begin
      wdg_reset <= 1'b0;
    end else begin
      wdg_reset <= expire & ~wdg_reset; // R4 R23
    end
  end

  // ****************************************
  // reset cause flags next state
  // ****************************************
  // set wins over software clear
  always @* begin
    flag_set  = 8'h00;
    flag_keep = flags;
    flag_set[`WDG_SCAN_BIT]    = scan_s; // R16
    flag_set[`WDG_TIMEOUT_BIT] = wdg_reset; // R17
    flag_set[`WDG_LOWSUP_BIT]  = low_s; // R18
    flag_set[`WDG_PIN_BIT]     = pin_s; // R19
    flag_set[`WDG_POWER_BIT]   = por_s; // R20
    // software may only clear a flag
    if (flag_wr)
      flag_keep = flags & bus_wdata; // R16 R17 R18 R19 R20
    // power-on clears all but its own flag
    if (por_s)
      flag_keep = flag_keep & (8'h01 << `WDG_POWER_BIT); // R16 R17 R18 R19
    next_flags = (flag_keep | flag_set) & `WDG_FLAGS_MASK;
    if (compat_mode)
      next_flags = next_flags & `WDG_COMPAT_MASK; // R21
  end

  // ****************************************
  // reset cause register
  // ****************************************
  // only nrst clears, chip resets other than power-on leave the causes
  always @(posedge clock) begin
    if (!nrst)
      flags <= `WDG_FLAGS_RESET;
    else
      flags <= next_flags;
  end

  // ****************************************
  // read data and status outputs
  // ****************************************
  // read data valid the cycle after the strobe
  always @(posedge clock) begin
    if (!nrst) begin
      bus_rdata  <= 8'h00;
      wdg_active <= 1'b0;
    end else begin
      if (bus_rd && ctrl_hit)
        bus_rdata <= ctrl_view; // R22
      else if (bus_rd && flag_hit)
        bus_rdata <= flags; // R22
      else if (bus_rd)
        bus_rdata <= 8'h00;
      wdg_active <= ctrl_view[`WDG_EN_BIT];
    end
  end

endmodule

`default_nettype wire

/* shared/wdg_defines.vh */
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH

// ****************************************
// register map
// ****************************************
`define WDG_CTRL_IO      8'h21
`define WDG_FLAGS_IO     8'h34
`define WDG_DATA_OFFSET  8'h20
`define WDG_CTRL_RESET   8'h00
`define WDG_FLAGS_RESET  8'h00

// ****************************************
// control fields
// ****************************************
`define WDG_CE_BIT       4
`define WDG_EN_BIT       3
`define WDG_PS_HI        2
`define WDG_PS_LO        0

// ****************************************
// reset cause fields
// ****************************************
`define WDG_SCAN_BIT     4
`define WDG_TIMEOUT_BIT  3
`define WDG_LOWSUP_BIT   2
`define WDG_PIN_BIT      1
`define WDG_POWER_BIT    0
`define WDG_COMPAT_MASK  8'h03
`define WDG_FLAGS_MASK   8'h1F

// ****************************************
// safety levels
// ****************************************
`define WDG_LEVEL0       2'h0
`define WDG_LEVEL1       2'h1
`define WDG_LEVEL2       2'h2

// ****************************************
// timing
// ****************************************
`define WDG_CE_CYCLES    3'h4
`define WDG_OSC_FREQ_HZ  1000000
`define WDG_BASE_PERIOD  16384
`define WDG_CNT_WIDTH    21

`endif

/* logic/wdg_sync.v */
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser for pin levels, no reset on the data path
module wdg_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // ****************************************
  // synchroniser stages
  // ****************************************
  // first stage feeds only the second
  always @(posedge clock) begin
    meta   <= d;
    stable <= meta;
  end

  assign q = stable;

endmodule

`default_nettype wire

/* logic/wdg_counter.v */
`timescale 1ns/1ns
`default_nettype none

// oscillator cycle counter with selectable expiry period
module wdg_counter #(
  parameter WIDTH = 21,
  parameter BASE  = 16384
) (
  input  wire       clock,
  input  wire       nrst,
  input  wire       tick,
  input  wire       clear,
  input  wire       run,
  input  wire [2:0] sel,
  output reg        expire
);

  localparam [WIDTH-1:0] BASE_W = BASE[WIDTH-1:0];

  reg  [WIDTH-1:0] count;
  wire [WIDTH-1:0] limit;

  // period doubles per select step
  assign limit = (BASE_W << sel) - {{(WIDTH-1){1'b0}}, 1'b1};

  // ****************************************
  // count and expiry
  // ****************************************
  // clear has priority, expiry restarts the period
  always @(posedge clock) begin
    if (!nrst) begin
      count  <= {WIDTH{1'b0}};
      expire <= 1'b0;
    end else if (clear || !run) begin
      count  <= {WIDTH{1'b0}};
      expire <= 1'b0;
    end else if (tick) begin
      if (count >= limit) begin
        count  <= {WIDTH{1'b0}};
        expire <= 1'b1;
      end else begin
        count  <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        expire <= 1'b0;
      end
    end else begin
      expire <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* verification/wdg_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// port checker for the watchdog block
// ****************************************
module wdg_props #(
  parameter BASE_PERIOD = 16384,
  parameter CNT_WIDTH   = 21
) (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [7:0] bus_addr,
  input wire logic       bus_io,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic       wdg_reset,
  input wire logic       wdg_active,
  input wire logic [1:0] safety_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // decoded read requests
  wire logic rd_ctl = bus_rd && bus_addr == (bus_io ? 8'h21 : 8'h41);
  wire logic rd_flg = bus_rd && bus_addr == (bus_io ? 8'h34 : 8'h54);
  wire logic rd_bad = bus_rd && bus_io && bus_addr != 8'h21
                      && bus_addr != 8'h34;

  pulse_width_a: assert property (wdg_reset |=> !wdg_reset)
    else $error("chip reset request longer than one cycle");
  expiry_cause_a: assert property (wdg_reset |-> $past(wdg_active))
    else $error("chip reset request while watchdog off");
  reset_disables_a: assert property (
    wdg_reset && safety_level != 2'h2 |-> ##[1:3] !wdg_active)
    else $error("watchdog still on after its own reset");
  level_fixed_a: assert property (
    $past(nrst, 2) |-> $stable(safety_level))
    else $error("safety level changed in operation");
  enable_cause_a: assert property (
    $rose(wdg_active) |-> $past(bus_wr) || $past(bus_wr, 2)
    || safety_level == 2'h2)
    else $error("watchdog enabled without a write");
  never_off_a: assert property (
    $fell(wdg_active) |-> safety_level != 2'h2)
    else $error("watchdog turned off at level two");
  level2_reads_a: assert property (
    rd_ctl && safety_level == 2'h2 |=> bus_rdata[3])
    else $error("enable reads zero at level two");
  unmapped_a: assert property (rd_bad |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  compat_flags_a: assert property (
    rd_flg && safety_level == 2'h0 |=> bus_rdata[4:2] == 3'h0)
    else $error("missing flags read nonzero");
  upper_zero_a: assert property (rd_ctl |=> bus_rdata[7:5] == 3'h0)
    else $error("control upper bits nonzero");

  cover property (wdg_reset);
  cover property (rd_ctl && safety_level == 2'h2);
  cover property ($fell(wdg_active));
endmodule

bind wdg_top wdg_props #(
  .BASE_PERIOD(BASE_PERIOD),
  .CNT_WIDTH  (CNT_WIDTH)
) u_wdg_props (
  .clock(clock), .nrst(nrst), .bus_addr(bus_addr), .bus_io(bus_io),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .wdg_reset(wdg_reset), .wdg_active(wdg_active),
  .safety_level(safety_level)
);
`default_nettype wire

/* verification/wdg_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// core side: register cycles, clear strobe
// ****************************************
module wdg_core_model (
  input  wire logic       clock,
  input  wire logic [7:0] bus_rdata,
  output var  logic [7:0] bus_addr,
  output var  logic       bus_io,
  output var  logic       bus_wr,
  output var  logic       bus_rd,
  output var  logic [7:0] bus_wdata,
  output var  logic       wdg_clear
);
  // idle bus at time zero
  initial begin
    bus_addr = 8'h00;
    bus_io = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
    wdg_clear = 1'b0;
  end

  // one bus cycle; released lines show scrambled values
  task automatic cycle(input logic wr, input logic [7:0] a,
                       input logic io, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge clock);
    #1 bus_addr = a;
    bus_io = io;
    bus_wdata = d;
    bus_wr = wr;
    bus_rd = !wr;
    @(posedge clock);
    #1 q = bus_rdata;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask

  // opening write, then the change two cycles later
  task automatic timed_write(input logic [7:0] d);
    logic [7:0] q;
    cycle(1'b1, 8'h21, 1'b1, 8'h18, q);
    cycle(1'b1, 8'h21, 1'b1, d & 8'h0F, q);
  endtask

  // clear instruction strobe
  task automatic clear_pulse();
    @(posedge clock);
    #1 wdg_clear = 1'b1;
    @(posedge clock);
    #1 wdg_clear = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// watchdog testbench
// ****************************************
module testbench;
  localparam int BP = 4;
  logic            clock, nrst, osc_clock, compat, always_on;
  logic      [3:0] src;
  wire logic [7:0] bus_addr, bus_wdata, bus_rdata;
  wire logic       bus_io, bus_wr, bus_rd, wdg_clear;
  wire logic       wdg_reset, wdg_active;
  wire logic [1:0] safety_level;
  int              err_total = 0;
  int              compares = 0;
  int              n_rst = 0;

  wdg_top #(.BASE_PERIOD(BP)) u_wdg_top (
    .clock(clock), .nrst(nrst), .osc_clock(osc_clock),
    .legacy_compat_fuse(compat), .watchdog_always_on_fuse(always_on),
    .power_up_src(src[0]), .pin_reset_src(src[1]),
    .low_supply_src(src[2]), .scan_reset_src(src[3]),
    .wdg_clear(wdg_clear), .bus_addr(bus_addr), .bus_io(bus_io),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .wdg_reset(wdg_reset),
    .wdg_active(wdg_active), .safety_level(safety_level));
  wdg_core_model u_wdg_core_model (
    .clock(clock), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
    .bus_io(bus_io), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .wdg_clear(wdg_clear));

  // system clock and watchdog oscillator
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    osc_clock = 1'b0;
    forever #500 osc_clock = ~osc_clock;
  end
  always @(posedge clock) if (wdg_reset === 1'b1) n_rst++;

  task automatic check(input string what, input logic [7:0] exp, got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    u_wdg_core_model.cycle(1'b1, a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input string w, input logic [7:0] a,
                        input logic io, input logic [7:0] exp);
    logic [7:0] q;
    u_wdg_core_model.cycle(1'b0, a, io, 8'h00, q);
    check(w, exp, q);
  endtask
  task automatic do_reset(input logic c, a);
    nrst = 1'b0;
    compat = c;
    always_on = a;
    repeat (12) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic pulse(input logic [3:0] s);
    src = s;
    repeat (3) @(posedge clock);
    #1 src = 4'h0;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_basics();
    check("level", 8'h01, {6'h00, safety_level});
    rd_chk("control", 8'h21, 1'b1, 8'h00);
    pulse(4'h1);
    rd_chk("flags", 8'h54, 1'b0, 8'h01);
    rd_chk("unmapped", 8'h22, 1'b1, 8'h00);
  endtask
  task automatic t_window();
    wr(8'h21, 8'h08);
    repeat (2) @(posedge clock);
    #1 check("active", 8'h01, {7'h00, wdg_active});
    wr(8'h21, 8'h00);
    rd_chk("control", 8'h41, 1'b0, 8'h08);
    u_wdg_core_model.timed_write(8'h0B);
    rd_chk("control", 8'h21, 1'b1, 8'h0B);
    wr(8'h21, 8'h18);
    rd_chk("control", 8'h21, 1'b1, 8'h1B);
    repeat (4) @(posedge clock);
    rd_chk("control", 8'h21, 1'b1, 8'h0B);
    wr(8'h21, 8'h00);
    rd_chk("control", 8'h21, 1'b1, 8'h0B);
    u_wdg_core_model.timed_write(8'h00);
    rd_chk("control", 8'h21, 1'b1, 8'h00);
    check("active", 8'h00, {7'h00, wdg_active});
  endtask
  task automatic t_expire();
    int n;
    int s;
    for (s = 0; s < 2; s++) begin
      u_wdg_core_model.timed_write(8'h08 | s[7:0]);
      n = 0;
      while (wdg_reset !== 1'b1 && n < 400) begin
        @(posedge clock);
        #1 n++;
      end
      check("expiry", 8'h01, {7'h00, n >= ((BP * 10) << s) - 10
            && n <= ((BP * 10) << s) + 10});
      repeat (3) @(posedge clock);
      #1 rd_chk("flags", 8'h34, 1'b1, 8'h09);
      rd_chk("control", 8'h21, 1'b1, 8'h00);
    end
  endtask
  task automatic t_clear();
    int n;
    n = n_rst;
    wr(8'h21, 8'h08);
    repeat (12) begin
      repeat (15) @(posedge clock);
      u_wdg_core_model.clear_pulse();
    end
    check("reset count", n[7:0], n_rst[7:0]);
    u_wdg_core_model.timed_write(8'h00);
  endtask
  task automatic t_flags();
    logic [7:0] q;
    pulse(4'h2);
    rd_chk("flags", 8'h34, 1'b1, 8'h0B);
    pulse(4'h4);
    rd_chk("flags", 8'h34, 1'b1, 8'h0F);
    pulse(4'h8);
    rd_chk("flags", 8'h34, 1'b1, 8'h1F);
    u_wdg_core_model.cycle(1'b1, 8'h54, 1'b0, 8'h1E, q);
    rd_chk("flags", 8'h34, 1'b1, 8'h1E);
    pulse(4'h1);
    rd_chk("flags", 8'h34, 1'b1, 8'h01);
  endtask
  task automatic t_level0();
    do_reset(1'b1, 1'b0);
    check("level", 8'h00, {6'h00, safety_level});
    wr(8'h21, 8'h0D);
    wr(8'h21, 8'h02);
    rd_chk("control", 8'h21, 1'b1, 8'h0A);
    pulse(4'hA);
    rd_chk("flags", 8'h34, 1'b1, 8'h02);
  endtask
  task automatic t_level2();
    do_reset(1'b0, 1'b1);
    check("level", 8'h02, {6'h00, safety_level});
    rd_chk("control", 8'h21, 1'b1, 8'h08);
    u_wdg_core_model.timed_write(8'h00);
    rd_chk("control", 8'h21, 1'b1, 8'h08);
    u_wdg_core_model.clear_pulse();
    u_wdg_core_model.timed_write(8'h03);
    rd_chk("control", 8'h21, 1'b1, 8'h0B);
    check("active", 8'h01, {7'h00, wdg_active});
  endtask

  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    src = 4'h0;
    do_reset(1'b0, 1'b0);
    t_basics();
    t_window();
    t_expire();
    t_clear();
    t_flags();
    t_level0();
    t_level2();
    give_verdict();
  end
  // watchdog on the run itself
  initial begin
    #1000000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
